// file: design/cks_pkg.sv
// Constants and types for the clock source select and start-up block
package cks_pkg;

  // ==========================================================================
  // Clock select codes
  localparam logic [3:0] CKS_SRC_EXT = 4'h0;
  localparam logic [3:0] CKS_SRC_RC  = 4'h2;
  localparam logic [3:0] CKS_SRC_WDT = 4'h3;

  // Factory fuse values
  localparam logic [3:0] CKS_FACTORY_SEL = 4'h2;
  localparam logic [1:0] CKS_FACTORY_SUT = 2'h2;

  // Start-up codes
  localparam logic [1:0] CKS_SUT_NONE  = 2'h0;
  localparam logic [1:0] CKS_SUT_SHORT = 2'h1;
  localparam logic [1:0] CKS_SUT_LONG  = 2'h2;
  localparam logic [1:0] CKS_SUT_RSVD  = 2'h3;

  // Fuse polarity: a read of 1 is unprogrammed
  localparam logic CKS_FUSE_PROGRAMMED = 1'b0;

  // ==========================================================================
  // Timing counts, in cycles of the counted oscillator
  localparam int unsigned CKS_CNT_W      = 14;
  localparam int unsigned CKS_SLEEP_CK   = 6;
  localparam int unsigned CKS_RESET_CK   = 14;
  localparam int unsigned CKS_SHORT_WDT  = 512;
  localparam int unsigned CKS_LONG_WDT   = 8192;

  // ==========================================================================
  // Source classes
  typedef enum logic [2:0]
  {
    CLS_EXT     = 3'b000,
    CLS_RC      = 3'b001,
    CLS_WDT     = 3'b010,
    CLS_LF      = 3'b011,
    CLS_XTAL    = 3'b100,
    CLS_INVALID = 3'b101
  } cks_class_t;

  // Pin roles of the two shared port pins
  typedef enum logic [1:0]
  {
    ROLE_IO      = 2'b00,
    ROLE_CLK_IN  = 2'b01,
    ROLE_CLK_OUT = 2'b10,
    ROLE_OSC     = 2'b11
  } cks_role_t;

  // Sequencer states
  typedef enum logic [2:0]
  {
    ST_CAPTURE = 3'b000,
    ST_RST_CK  = 3'b001,
    ST_RST_WDT = 3'b010,
    ST_RUN     = 3'b011,
    ST_SLEEP   = 3'b100,
    ST_STARTUP = 3'b101
  } cks_state_t;

endpackage

// file: design/cks_timer.sv
// Cycle counter that times a start-up phase in oscillator ticks
`timescale 1ns/1ns
`default_nettype none
module cks_timer
  import cks_pkg::*;
#(
  parameter int unsigned W = CKS_CNT_W
)
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         start_in,
  input  wire logic [W-1:0] target_in,
  input  wire logic         tick_in,
  output logic              busy_out,
  output logic              done_out
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] target;
    logic         busy;
    logic         done;
  } cks_tmr_t;

  cks_tmr_t q;
  cks_tmr_t d;

  // ==========================================================================
  // Count ticks until the target is reached
  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    if (start_in)
    begin
      d.cnt    = '0;
      d.target = target_in;
      d.busy   = 1'b1;
    end
    else if (q.busy && tick_in)
    begin
      if (q.cnt == q.target - W'(1))
      begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
      else
      begin
        d.cnt = q.cnt + W'(1);
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign busy_out = q.busy;
  assign done_out = q.done;

endmodule
`default_nettype wire

// file: design/cks_top.sv
// Clock source selection, pin roles and start-up sequencing
// How it works
// - Four-bit select code decodes to external, RC, watchdog, low-frequency or crystal range.
// - Port pin roles follow the source: clock input, I/O, clock output or oscillator.
// - Source comes from fuses at reset, later from the select register.
// - Wake or source switch waits start-up cycles of the selected source.
// - Reset adds 512 or 8192 watchdog oscillator cycles per time-out code.
// - Reset copies fuse select and start-up codes into the select register.
// - Factory fuses give RC oscillator with longest reset delay.
// - Programmed divide-by-eight fuse starts system clock divided by eight.
// - Reset loads factory trim; software may rewrite the trim register.
// - Watchdog oscillator keeps running for watchdog and reset time-out.
// - RC source: 6 CK wake start-up, 14 CK plus optional reset delay.
// - Watchdog source: same 6 CK and 14 CK plus delay timings.
// - Start-up code 00 only allowed while reset pin disable fuse is unset.
// - Fuse bit 1 means unprogrammed, 0 means programmed.
// - ADC clock runs independently while CPU and I/O clocks halt.
`timescale 1ns/1ns
`default_nettype none
module cks_top
  import cks_pkg::*;
#(
  parameter int unsigned LONG_WDT_CYCLES = CKS_LONG_WDT
)
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] clock_select_fuses_in,
  input  wire logic [1:0] startup_time_fuses_in,
  input  wire logic       divide_by_eight_fuse_in,
  input  wire logic       reset_pin_disable_fuse_in,
  input  wire logic [7:0] factory_trim_in,
  input  wire logic       wdt_osc_in,
  input  wire logic       src_osc_in,
  input  wire logic       sel_write_in,
  input  wire logic [3:0] sel_wdata_in,
  input  wire logic [1:0] sut_wdata_in,
  input  wire logic       trim_write_in,
  input  wire logic [7:0] trim_wdata_in,
  input  wire logic       sleep_in,
  input  wire logic       wake_in,
  input  wire logic       clock_out_en_in,
  input  wire logic       adc_enable_in,
  output logic [3:0]      clock_select_field_out,
  output logic [1:0]      startup_time_field_out,
  output logic [7:0]      oscillator_trim_out,
  output logic [2:0]      src_class_out,
  output logic [1:0]      port_b_bit4_role_out,
  output logic [1:0]      port_b_bit5_role_out,
  output logic            sys_div8_out,
  output logic            cpu_clk_en_out,
  output logic            adc_clk_en_out,
  output logic            wdt_osc_en_out,
  output logic            config_error_out
);

  typedef struct packed {
    cks_state_t             st;
    logic [3:0]             sel;
    logic [1:0]             sut;
    logic [7:0]             trim;
    logic                   div8;
    logic                   cpu_en;
    logic                   adc_en;
    logic                   wdt_en;
    cks_class_t             cls;
    cks_role_t              pb4;
    cks_role_t              pb5;
    logic                   err;
    logic [2:0]             wsync;
    logic [2:0]             ssync;
    logic                   start;
    logic [CKS_CNT_W-1:0]   target;
    logic                   use_wdt;
  } cks_reg_t;

  cks_reg_t q;
  cks_reg_t d;
  logic     tmr_done;
  logic     tmr_tick;

  // ==========================================================================
  // Decode helpers
  function automatic cks_class_t src_class(input logic [3:0] sel);
    if (sel == CKS_SRC_EXT)
      return CLS_EXT;
    else if (sel == CKS_SRC_RC)
      return CLS_RC;
    else if (sel == CKS_SRC_WDT)
      return CLS_WDT;
    else if (sel[3:2] == 2'b01)
      return CLS_LF;
    else if (sel[3])
      return CLS_XTAL;
    else
      return CLS_INVALID;
  endfunction

  // Reserved codes, and 00 with the reset pin disabled, fall back to the long delay
  function automatic logic [1:0] eff_sut(input logic [1:0] sut, input logic rstdis);
    if (sut == CKS_SUT_RSVD)
      return CKS_SUT_LONG;
    else if (sut == CKS_SUT_NONE && rstdis == CKS_FUSE_PROGRAMMED)
      return CKS_SUT_LONG;
    else
      return sut;
  endfunction

  // Timer ticks are rising edges of the watchdog or source oscillator, synchronised into clk_in
  assign tmr_tick = q.use_wdt ? (q.wsync[1] & ~q.wsync[2]) : (q.ssync[1] & ~q.ssync[2]);

  cks_timer #(
    .W (CKS_CNT_W)
  ) u_timer (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .start_in  (q.start),
    .target_in (q.target),
    .tick_in   (tmr_tick),
    .busy_out  (),
    .done_out  (tmr_done)
  );

  // ==========================================================================
  // Sequencer
  always_comb
  begin
    d         = q;
    d.start   = 1'b0;
    d.wsync   = {q.wsync[1:0], wdt_osc_in};
    d.ssync   = {q.ssync[1:0], src_osc_in};
    d.adc_en  = adc_enable_in;
    d.wdt_en  = 1'b1;
    if (trim_write_in && q.st != ST_CAPTURE)
      d.trim = trim_wdata_in;
    case (q.st)
      ST_CAPTURE:
      begin
        d.sel     = clock_select_fuses_in;
        d.sut     = startup_time_fuses_in;
        d.trim    = factory_trim_in;
        d.div8    = (divide_by_eight_fuse_in == CKS_FUSE_PROGRAMMED);
        d.cpu_en  = 1'b0;
        d.start   = 1'b1;
        d.target  = CKS_CNT_W'(CKS_RESET_CK);
        d.use_wdt = 1'b0;
        d.st      = ST_RST_CK;
      end
      ST_RST_CK:
      begin
        if (tmr_done)
        begin
          case (eff_sut(q.sut, reset_pin_disable_fuse_in))
            CKS_SUT_SHORT:
            begin
              d.start   = 1'b1;
              d.target  = CKS_CNT_W'(CKS_SHORT_WDT);
              d.use_wdt = 1'b1;
              d.st      = ST_RST_WDT;
            end
            CKS_SUT_LONG:
            begin
              d.start   = 1'b1;
              d.target  = CKS_CNT_W'(LONG_WDT_CYCLES);
              d.use_wdt = 1'b1;
              d.st      = ST_RST_WDT;
            end
            default:
            begin
              d.cpu_en = 1'b1;
              d.st     = ST_RUN;
            end
          endcase
        end
      end
      ST_RST_WDT:
      begin
        if (tmr_done)
        begin
          d.cpu_en = 1'b1;
          d.st     = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (sel_write_in)
        begin
          d.sel     = sel_wdata_in;
          d.sut     = sut_wdata_in;
          d.cpu_en  = 1'b0;
          d.start   = 1'b1;
          d.target  = CKS_CNT_W'(CKS_SLEEP_CK);
          d.use_wdt = 1'b0;
          d.st      = ST_STARTUP;
        end
        else if (sleep_in)
        begin
          d.cpu_en = 1'b0;
          d.st     = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (wake_in)
        begin
          d.start   = 1'b1;
          d.target  = CKS_CNT_W'(CKS_SLEEP_CK);
          d.use_wdt = 1'b0;
          d.st      = ST_STARTUP;
        end
      end
      ST_STARTUP:
      begin
        if (tmr_done)
        begin
          d.cpu_en = 1'b1;
          d.st     = ST_RUN;
        end
      end
      default:
      begin
        d.st = ST_CAPTURE;
      end
    endcase
    d.cls = src_class(d.sel);
    d.err = (d.cls == CLS_INVALID) || (d.sut == CKS_SUT_RSVD)
            || (d.sut == CKS_SUT_NONE && reset_pin_disable_fuse_in == CKS_FUSE_PROGRAMMED);
    case (d.cls)
      CLS_EXT:
      begin
        d.pb4 = ROLE_CLK_IN;
        d.pb5 = clock_out_en_in ? ROLE_CLK_OUT : ROLE_IO;
      end
      CLS_RC, CLS_WDT:
      begin
        d.pb4 = ROLE_IO;
        d.pb5 = clock_out_en_in ? ROLE_CLK_OUT : ROLE_IO;
      end
      CLS_LF, CLS_XTAL:
      begin
        d.pb4 = ROLE_OSC;
        d.pb5 = ROLE_OSC;
      end
      default:
      begin
        d.pb4 = ROLE_IO;
        d.pb5 = ROLE_IO;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      q        <= '0;
      q.st     <= ST_CAPTURE;
      q.sel    <= CKS_FACTORY_SEL;
      q.sut    <= CKS_FACTORY_SUT;
      q.cls    <= CLS_RC;
      q.wdt_en <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign clock_select_field_out = q.sel;
  assign startup_time_field_out = q.sut;
  assign oscillator_trim_out    = q.trim;
  assign src_class_out          = q.cls;
  assign port_b_bit4_role_out   = q.pb4;
  assign port_b_bit5_role_out   = q.pb5;
  assign sys_div8_out           = q.div8;
  assign cpu_clk_en_out         = q.cpu_en;
  assign adc_clk_en_out         = q.adc_en;
  assign wdt_osc_en_out         = q.wdt_en;
  assign config_error_out       = q.err;

  // ==========================================================================
  // Checks
  a_fuse_copy_sel: assert property (@(posedge clk_in) disable iff (rst_in)
    q.st == ST_CAPTURE |=> clock_select_field_out == $past(clock_select_fuses_in)
                           && startup_time_field_out == $past(startup_time_fuses_in))
    else $error("select fields not copied from fuses");
  a_trim_load: assert property (@(posedge clk_in) disable iff (rst_in)
    q.st == ST_CAPTURE |=> oscillator_trim_out == $past(factory_trim_in))
    else $error("trim not loaded at reset");
  a_div8_fuse: assert property (@(posedge clk_in) disable iff (rst_in)
    q.st == ST_CAPTURE |=> sys_div8_out == !$past(divide_by_eight_fuse_in))
    else $error("divide by eight does not follow fuse");
  a_cpu_gated: assert property (@(posedge clk_in) disable iff (rst_in)
    cpu_clk_en_out |-> q.st == ST_RUN)
    else $error("cpu clock enabled before start-up done");
  a_switch_gates: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.st == ST_RUN && sel_write_in) |=> !cpu_clk_en_out ##1 !cpu_clk_en_out)
    else $error("cpu clock not gated on source switch");
  a_wdt_running: assert property (@(posedge clk_in) disable iff (rst_in)
    wdt_osc_en_out)
    else $error("watchdog oscillator stopped");
  a_adc_free: assert property (@(posedge clk_in) disable iff (rst_in)
    adc_clk_en_out == $past(adc_enable_in))
    else $error("adc clock does not follow its enable");
  a_pin_roles: assert property (@(posedge clk_in) disable iff (rst_in)
    (clock_select_field_out[3] || clock_select_field_out[3:2] == 2'b01)
      |-> port_b_bit4_role_out == ROLE_OSC && port_b_bit5_role_out == ROLE_OSC)
    else $error("oscillator pins not assigned");
  a_decode_rc: assert property (@(posedge clk_in) disable iff (rst_in)
    clock_select_field_out == CKS_SRC_RC |-> src_class_out == CLS_RC
      && port_b_bit4_role_out == ROLE_IO)
    else $error("rc source decode wrong");
  a_sut00_locked: assert property (@(posedge clk_in) disable iff (rst_in)
    (q.st == ST_RST_CK && tmr_done && q.sut == CKS_SUT_NONE && !reset_pin_disable_fuse_in)
      |=> q.st == ST_RST_WDT && q.target == CKS_CNT_W'(LONG_WDT_CYCLES))
    else $error("code 00 accepted with reset pin disabled");

  c_reset_long: cover property (@(posedge clk_in) disable iff (rst_in)
    q.st == ST_RST_WDT && tmr_done);
  c_wake: cover property (@(posedge clk_in) disable iff (rst_in)
    q.st == ST_STARTUP && tmr_done);
  c_switch: cover property (@(posedge clk_in) disable iff (rst_in)
    q.st == ST_RUN && sel_write_in);

endmodule
`default_nettype wire

// file: tb/cks_top_bench.sv
// Self-checking testbench for the clock source select and start-up block
`timescale 1ns/1ns
`default_nettype none
module cks_top_bench
  import cks_pkg::*;
;
  localparam int unsigned LONG_N = 16;

  logic       clk_in;
  logic       rst_in;
  logic [3:0] clock_select_fuses_in;
  logic [1:0] startup_time_fuses_in;
  logic       divide_by_eight_fuse_in;
  logic       reset_pin_disable_fuse_in;
  logic [7:0] factory_trim_in;
  logic       wdt_osc_in;
  logic       src_osc_in;
  logic       sel_write_in;
  logic [3:0] sel_wdata_in;
  logic [1:0] sut_wdata_in;
  logic       trim_write_in;
  logic [7:0] trim_wdata_in;
  logic       sleep_in;
  logic       wake_in;
  logic       clock_out_en_in;
  logic       adc_enable_in;
  logic [3:0] clock_select_field_out;
  logic [1:0] startup_time_field_out;
  logic [7:0] oscillator_trim_out;
  logic [2:0] src_class_out;
  logic [1:0] port_b_bit4_role_out;
  logic [1:0] port_b_bit5_role_out;
  logic       sys_div8_out;
  logic       cpu_clk_en_out;
  logic       adc_clk_en_out;
  logic       wdt_osc_en_out;
  logic       config_error_out;
  int         errors;
  int         compares;

  cks_top #(.LONG_WDT_CYCLES(LONG_N)) uut
  (
    .clk_in                    (clk_in),
    .rst_in                    (rst_in),
    .clock_select_fuses_in     (clock_select_fuses_in),
    .startup_time_fuses_in     (startup_time_fuses_in),
    .divide_by_eight_fuse_in   (divide_by_eight_fuse_in),
    .reset_pin_disable_fuse_in (reset_pin_disable_fuse_in),
    .factory_trim_in           (factory_trim_in),
    .wdt_osc_in                (wdt_osc_in),
    .src_osc_in                (src_osc_in),
    .sel_write_in              (sel_write_in),
    .sel_wdata_in              (sel_wdata_in),
    .sut_wdata_in              (sut_wdata_in),
    .trim_write_in             (trim_write_in),
    .trim_wdata_in             (trim_wdata_in),
    .sleep_in                  (sleep_in),
    .wake_in                   (wake_in),
    .clock_out_en_in           (clock_out_en_in),
    .adc_enable_in             (adc_enable_in),
    .clock_select_field_out    (clock_select_field_out),
    .startup_time_field_out    (startup_time_field_out),
    .oscillator_trim_out       (oscillator_trim_out),
    .src_class_out             (src_class_out),
    .port_b_bit4_role_out      (port_b_bit4_role_out),
    .port_b_bit5_role_out      (port_b_bit5_role_out),
    .sys_div8_out              (sys_div8_out),
    .cpu_clk_en_out            (cpu_clk_en_out),
    .adc_clk_en_out            (adc_clk_en_out),
    .wdt_osc_en_out            (wdt_osc_en_out),
    .config_error_out          (config_error_out)
  );

  // ==========================================================================
  // Clock, helpers
  initial clk_in = 1'b0;
  always #50 clk_in = ~clk_in;

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Oscillator ticks: each half wave lasts two system cycles
  task automatic tick(input bit wdt, input int n);
    repeat (n)
    begin
      if (wdt) wdt_osc_in = 1'b1; else src_osc_in = 1'b1;
      cyc(2);
      if (wdt) wdt_osc_in = 1'b0; else src_osc_in = 1'b0;
      cyc(2);
    end
  endtask

  task automatic wait_high();
    int i;
    for (i = 0; i < 12 && cpu_clk_en_out !== 1'b1; i++) cyc(1);
    check(cpu_clk_en_out, 1'b1);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [6:0] exp_dec(input logic [3:0] c, input logic co);
    logic [1:0] b5;
    b5 = co ? ROLE_CLK_OUT : ROLE_IO;
    if (c == 4'h0) return {CLS_EXT, ROLE_CLK_IN, b5};
    if (c == 4'h2) return {CLS_RC, ROLE_IO, b5};
    if (c == 4'h3) return {CLS_WDT, ROLE_IO, b5};
    if (c[3:2] == 2'b01) return {CLS_LF, ROLE_OSC, ROLE_OSC};
    if (c[3]) return {CLS_XTAL, ROLE_OSC, ROLE_OSC};
    return {CLS_INVALID, ROLE_IO, ROLE_IO};
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_reset_values();
    check(clock_select_field_out, 4'h2);
    check(startup_time_field_out, 2'h2);
    check(cpu_clk_en_out, 1'b0);
    check(wdt_osc_en_out, 1'b1);
    check(config_error_out, 1'b0);
  endtask

  // Boot with given fuses, then time the 14 source ticks and the added delay
  task automatic t_boot(input logic [3:0] sel, input logic [1:0] sut, input logic div8,
                        input logic rdis, input int nwdt, input logic err);
    logic [6:0] e;
    clock_select_fuses_in = sel;
    startup_time_fuses_in = sut;
    divide_by_eight_fuse_in = div8;
    reset_pin_disable_fuse_in = rdis;
    factory_trim_in = {sel, 2'h1, sut};
    rst_in = 1'b1;
    cyc(2);
    check(wdt_osc_en_out, 1'b1);
    rst_in = 1'b0;
    cyc(2);
    check(clock_select_field_out, sel);
    check(startup_time_field_out, sut);
    check(oscillator_trim_out, {sel, 2'h1, sut});
    check(sys_div8_out, !div8);
    check(config_error_out, err);
    e = exp_dec(sel, clock_out_en_in);
    check(src_class_out, e[6:4]);
    check({port_b_bit4_role_out, port_b_bit5_role_out}, e[3:0]);
    tick(1'b0, 13);
    cyc(6);
    check(cpu_clk_en_out, 1'b0);
    tick(1'b0, 1);
    if (nwdt > 0)
    begin
      cyc(6);
      check(cpu_clk_en_out, 1'b0);
      tick(1'b1, nwdt - 1);
      cyc(6);
      check(cpu_clk_en_out, 1'b0);
      tick(1'b1, 1);
    end
    wait_high();
  endtask

  // Every select code through the dynamic switch, six ticks each
  task automatic t_decode();
    int c;
    logic [6:0] e;
    for (c = 0; c < 16; c++)
    begin
      clock_out_en_in = ~c[0];
      sel_wdata_in = c[3:0];
      sut_wdata_in = 2'h2;
      sel_write_in = 1'b1;
      cyc(1);
      sel_write_in = 1'b0;
      e = exp_dec(c[3:0], ~c[0]);
      check(clock_select_field_out, c[3:0]);
      check(src_class_out, e[6:4]);
      check({port_b_bit4_role_out, port_b_bit5_role_out}, e[3:0]);
      check(config_error_out, c == 1);
      check(cpu_clk_en_out, 1'b0);
      tick(1'b0, 5);
      cyc(6);
      check(cpu_clk_en_out, 1'b0);
      tick(1'b0, 1);
      wait_high();
    end
  endtask

  // Sleep, refused switch while asleep, ADC domain, then wake timing
  task automatic t_sleep_wake();
    sleep_in = 1'b1;
    cyc(1);
    sleep_in = 1'b0;
    check(cpu_clk_en_out, 1'b0);
    adc_enable_in = 1'b1;
    sel_wdata_in = 4'h0;
    sel_write_in = 1'b1;
    cyc(1);
    sel_write_in = 1'b0;
    adc_enable_in = 1'b0;
    check(adc_clk_en_out, 1'b1);
    check(clock_select_field_out, 4'hf);
    cyc(1);
    check(adc_clk_en_out, 1'b0);
    tick(1'b0, 3);
    check(cpu_clk_en_out, 1'b0);
    wake_in = 1'b1;
    cyc(1);
    wake_in = 1'b0;
    tick(1'b0, 5);
    cyc(6);
    check(cpu_clk_en_out, 1'b0);
    tick(1'b0, 1);
    wait_high();
  endtask

  task automatic t_trim();
    trim_wdata_in = 8'hc3;
    trim_write_in = 1'b1;
    cyc(1);
    trim_write_in = 1'b0;
    check(oscillator_trim_out, 8'hc3);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    errors = 0;
    compares = 0;
    rst_in = 1'b1;
    clock_select_fuses_in = CKS_FACTORY_SEL;
    startup_time_fuses_in = CKS_FACTORY_SUT;
    divide_by_eight_fuse_in = 1'b0;
    reset_pin_disable_fuse_in = 1'b1;
    factory_trim_in = 8'h5a;
    wdt_osc_in = 1'b0;
    src_osc_in = 1'b0;
    sel_write_in = 1'b0;
    sel_wdata_in = 4'h0;
    sut_wdata_in = 2'h0;
    trim_write_in = 1'b0;
    trim_wdata_in = 8'h00;
    sleep_in = 1'b0;
    wake_in = 1'b0;
    clock_out_en_in = 1'b1;
    adc_enable_in = 1'b0;
    cyc(5);
    t_reset_values();
    t_boot(4'h2, 2'h2, 1'b0, 1'b1, LONG_N, 1'b0);
    t_boot(4'h2, 2'h0, 1'b1, 1'b1, 0, 1'b0);
    t_boot(4'h2, 2'h1, 1'b1, 1'b1, 512, 1'b0);
    t_boot(4'h3, 2'h2, 1'b1, 1'b1, LONG_N, 1'b0);
    t_boot(4'h3, 2'h0, 1'b0, 1'b0, LONG_N, 1'b1);
    t_boot(4'h2, 2'h3, 1'b1, 1'b1, LONG_N, 1'b1);
    t_trim();
    t_decode();
    t_sleep_wake();
    tally_and_finish();
  end

  initial
  begin
    #3_000_000;
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
